// file: deser_regs_pkg.sv
// Package of offsets, reset values, field positions and types for the block.
package deser_regs_pkg;

    // ********************************************************
    // Register offsets (byte addresses on the plain port).
    // ********************************************************
    localparam logic [7:0] OFS_PIN_CTRL = 8'h06;
    localparam logic [7:0] OFS_RSVD7 = 8'h07;
    localparam logic [7:0] OFS_SYNC_FILT = 8'h08;
    localparam logic [7:0] OFS_RSVD9 = 8'h09;
    localparam logic [7:0] OFS_RSVD10 = 8'h0A;
    localparam logic [7:0] OFS_RSVD11 = 8'h0B;
    localparam logic [7:0] OFS_ERR_THR = 8'h0C;
    localparam logic [7:0] OFS_DEC_ERR = 8'h0D;
    localparam logic [7:0] OFS_PAT_ERR = 8'h0E;
    localparam logic [7:0] OFS_AUD_CLK = 8'h12;
    localparam logic [7:0] OFS_RSVD19 = 8'h13;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h21;

    // ********************************************************
    // Reset values.
    // ********************************************************
    localparam logic [7:0] RST_PIN_CTRL = 8'h0A;
    localparam logic [7:0] RST_RSVD7 = 8'h54;
    localparam logic [7:0] RST_SYNC_FILT = 8'h30;
    localparam logic [7:0] RST_RSVD9 = 8'hC8;
    localparam logic [7:0] RST_RSVD10 = 8'h12;
    localparam logic [7:0] RST_RSVD11 = 8'h20;
    localparam logic [7:0] RST_ERR_THR = 8'h00;
    localparam logic [7:0] RST_AUD_CLK = 8'h00;
    localparam logic [4:0] RST_RSVD19 = 5'h10;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // ********************************************************
    // Field positions.
    // ********************************************************
    localparam int BIT_AUTO_CLR = 6;
    localparam int BIT_IRQ_FWD_DIS = 5;
    localparam int BIT_IRQ_IN = 4;
    localparam int BIT_GP1_OUT = 3;
    localparam int BIT_GP1_IN = 2;
    localparam int BIT_GP0_OUT = 1;
    localparam int BIT_GP0_IN = 0;
    localparam int BIT_VS_FILT_DIS = 1;
    localparam int BIT_HS_FILT_DIS = 0;
    localparam int BIT_AUD_SRC = 7;

    // Interrupt status bits: decode error, pattern error, error pin set.
    localparam int IRQ_DEC = 0;
    localparam int IRQ_PAT = 1;
    localparam int IRQ_THR = 2;

    // Glitch filter length in clocks: a sync level must stand this long.
    localparam logic [1:0] FILT_LEN = 2'h3;

    // Register bus request carried as one struct.
    typedef struct packed {
        logic [7:0] addr;  // Byte address.
        logic [7:0] wdata; // Write data.
        logic wr;          // Write strobe.
        logic rd;          // Read strobe.
    } bus_req_s;

    // Sync filter state; each step one bit apart except FS_TAKE back to FS_STEADY, which flips both.
    typedef enum logic [1:0] {
        FS_STEADY = 2'b00,
        FS_CHANGE = 2'b01,
        FS_TAKE = 2'b11
    } filt_state_e;

endpackage

// file: deser_status_gpio_regs.sv
// Control and status registers of the serial-link video deserializer.
// Operation
// - Auto-clear bit clears error counters and output
// - Forward interrupts unless forward-disable bit set
// - Read-only bit shows interrupt input level
// - Pin one driven from value bit, readback
// - Pin zero driven from value bit, readback
// - Vertical sync filter unless disable bit set
// - Horizontal sync filter unless disable bit set
// - Error output low when count exceeds threshold
// - Eight-bit decode error counter, reset zero
// - Decode counter held zero in pattern mode
// - Audio clock source, seven-bit divider, zero off
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module deser_status_gpio_regs (
    input wire logic clock,                          // Device clock.
    input wire logic rst_n,                          // Async reset, low.
    input wire deser_regs_pkg::bus_req_s bus_req,    // Register request.
    output logic [7:0] rdata,                        // Read data, next cycle.
    input wire logic irq_in,                         // Interrupt input pin.
    output logic irq_forward,                        // Interrupt to link.
    input wire logic gp_pin_one_in,                  // Pin one level.
    output logic gp_pin_one_out,                     // Pin one drive level.
    output logic gp_pin_one_oe,                      // Pin one enable.
    input wire logic gp_pin_zero_in,                 // Pin zero level.
    output logic gp_pin_zero_out,                    // Pin zero drive level.
    output logic gp_pin_zero_oe,                     // Pin zero enable.
    input wire logic vsync_in,                       // Recovered vsync.
    input wire logic hsync_in,                       // Recovered hsync.
    output logic vsync_out,                          // Vsync after filter.
    output logic hsync_out,                          // Hsync after filter.
    input wire logic decode_error,                   // One decode error.
    input wire logic pattern_mode,                   // Pattern test active.
    input wire logic pattern_error,                  // One pattern mismatch.
    output logic error_n,                            // Error output, low.
    input wire logic recovered_pixel_clock,          // Pixel clock level.
    input wire logic osc_clock,                      // Oscillator level.
    output logic audio_mclk,                         // Audio master clock.
    output logic irq                                 // Interrupt, high.
);
    import deser_regs_pkg::*;

    // ********************************************************
    // Register storage.
    // ********************************************************
    logic [7:0] pin_ctrl_r;      // Writable bits of the pin control.
    logic [1:0] sync_filt_r;     // Filter disable bits.
    logic [7:0] err_thr_r;       // Error threshold.
    logic [7:0] decode_error_count_r; // Decode error counter.
    logic [7:0] pattern_error_count_r; // Pattern error counter.
    logic [7:0] aud_clk_r;       // Audio clock source and divider.
    logic [7:0] irq_stat_r;      // Sticky interrupt status.
    logic [7:0] irq_mask_r;      // Interrupt mask.
    logic [7:0] rdata_nxt;       // Read data before the flop.
    logic wr_en;                 // Write strobe.
    logic auto_error_clear;      // Auto-clear control.
    logic irq_forward_disable;   // Forwarding off.
    logic [7:0] irq_set;         // Events this cycle.
    logic error_active;          // Count above threshold.

    assign wr_en = bus_req.wr;
    assign auto_error_clear = pin_ctrl_r[BIT_AUTO_CLR];
    assign irq_forward_disable = pin_ctrl_r[BIT_IRQ_FWD_DIS];

    // ********************************************************
    // Register writes.
    // ********************************************************
    // Software-written control registers; read-only bits are not stored.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_ctrl_r <= RST_PIN_CTRL;
            sync_filt_r <= RST_SYNC_FILT[1:0];
            err_thr_r <= RST_ERR_THR;
            aud_clk_r <= RST_AUD_CLK;
            irq_mask_r <= RST_IRQ_MASK;
        end else if (wr_en) begin
            unique case (bus_req.addr)
                // Only the writable bits are taken; bit 7 stays zero.
                OFS_PIN_CTRL: pin_ctrl_r <= bus_req.wdata & 8'h6A;
                OFS_SYNC_FILT: sync_filt_r <= bus_req.wdata[1:0];
                OFS_ERR_THR: err_thr_r <= bus_req.wdata;
                OFS_AUD_CLK: aud_clk_r <= bus_req.wdata;
                OFS_IRQ_MASK: irq_mask_r <= bus_req.wdata;
                default: begin
                    // Read-only and reserved writes are ignored.
                end
            endcase
        end
    end

    // ********************************************************
    // Error counters.
    // ********************************************************
    // Decode errors saturate at 0xFF so a storm never wraps to a low count.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            decode_error_count_r <= 8'h00;
        end else if (pattern_mode || auto_error_clear) begin
            decode_error_count_r <= 8'h00;
        end else if (decode_error && decode_error_count_r != 8'hFF) begin
            decode_error_count_r <= decode_error_count_r + 8'h01;
        end
    end

    // Pattern mismatches counted only in pattern mode, also saturating.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pattern_error_count_r <= 8'h00;
        end else if (auto_error_clear) begin
            pattern_error_count_r <= 8'h00;
        end else if (pattern_mode && pattern_error
                     && pattern_error_count_r != 8'hFF) begin
            pattern_error_count_r <= pattern_error_count_r + 8'h01;
        end
    end

    assign error_active = decode_error_count_r > err_thr_r;

    // Error output from a flop; auto-clear forces it inactive at the next clock edge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            error_n <= 1'b1;
        end else begin
            error_n <= ~(error_active && !auto_error_clear);
        end
    end

    // ********************************************************
    // Interrupt forwarding and pins.
    // ********************************************************
    // Forwarding and pin drive are flopped so every output is a register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_forward <= 1'b0;
            gp_pin_one_out <= 1'b1;
            gp_pin_zero_out <= 1'b1;
            gp_pin_one_oe <= 1'b0;
            gp_pin_zero_oe <= 1'b0;
        end else begin
            irq_forward <= irq_in && !irq_forward_disable;
            gp_pin_one_out <= pin_ctrl_r[BIT_GP1_OUT];
            gp_pin_one_oe <= 1'b1;
            gp_pin_zero_out <= pin_ctrl_r[BIT_GP0_OUT];
            gp_pin_zero_oe <= 1'b1;
        end
    end

    // ********************************************************
    // Sync glitch filters.
    // ********************************************************
    // One filter per sync line; a new level must hold FILT_LEN clocks.
    // Limitation: filtering delays the sync edge by that many clocks plus one.
    logic [1:0] sync_raw;     // Vsync at 1, hsync at 0.
    logic [1:0] sync_filt;    // Filtered levels.
    logic [1:0] sync_sel_r;   // Selected output levels.
    assign sync_raw = {vsync_in, hsync_in};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filt
            filt_state_e st_r;        // Filter state.
            logic lvl_r;              // Accepted level.
            logic [1:0] cnt_r;        // Stable-cycle count.
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    st_r <= FS_STEADY;
                    lvl_r <= 1'b0;
                    cnt_r <= 2'h0;
                end else begin
                    unique case (st_r)
                        FS_STEADY: begin
                            cnt_r <= 2'h1;
                            if (sync_raw[g] != lvl_r) begin
                                st_r <= FS_CHANGE;
                            end
                        end
                        FS_CHANGE: begin
                            if (sync_raw[g] == lvl_r) begin
                                // A glitch: drop it.
                                st_r <= FS_STEADY;
                            end else if (cnt_r + 2'h1 >= FILT_LEN) begin
                                st_r <= FS_TAKE;
                            end else begin
                                cnt_r <= cnt_r + 2'h1;
                            end
                        end
                        FS_TAKE: begin
                            lvl_r <= ~lvl_r;
                            st_r <= FS_STEADY;
                        end
                        default: st_r <= FS_STEADY;
                    endcase
                end
            end
            assign sync_filt[g] = lvl_r;
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_sel_r <= 2'b00;
        end else begin
            sync_sel_r[1] <= sync_filt_r[BIT_VS_FILT_DIS] ? sync_raw[1]
                                                         : sync_filt[1];
            sync_sel_r[0] <= sync_filt_r[BIT_HS_FILT_DIS] ? sync_raw[0]
                                                         : sync_filt[0];
        end
    end
    assign vsync_out = sync_sel_r[1];
    assign hsync_out = sync_sel_r[0];

    // ********************************************************
    // Audio master clock.
    // ********************************************************
    // The source levels are sampled as data; the divider counts rising
    // edges of the chosen source and toggles every divider-value edges.
    logic src_r;              // Source level last cycle.
    logic src_now;            // Chosen source level.
    logic [6:0] div_cnt_r;    // Edge count.
    logic [6:0] div_val;      // Divider setting.
    assign div_val = aud_clk_r[6:0];
    assign src_now = aud_clk_r[BIT_AUD_SRC] ? osc_clock
                                            : recovered_pixel_clock;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_r <= 1'b0;
            div_cnt_r <= 7'h00;
            audio_mclk <= 1'b0;
        end else begin
            src_r <= src_now;
            if (div_val == 7'h00) begin
                div_cnt_r <= 7'h00;
                audio_mclk <= 1'b0;
            end else if (src_now && !src_r) begin
                if (div_cnt_r + 7'h01 >= div_val) begin
                    div_cnt_r <= 7'h00;
                    audio_mclk <= ~audio_mclk;
                end else begin
                    div_cnt_r <= div_cnt_r + 7'h01;
                end
            end
        end
    end

    // ********************************************************
    // Interrupt status and output.
    // ********************************************************
    always_comb begin
        irq_set = 8'h00;
        irq_set[IRQ_DEC] = decode_error && !pattern_mode;
        irq_set[IRQ_PAT] = pattern_error && pattern_mode;
        irq_set[IRQ_THR] = error_active && error_n;
    end

    // Write-one-to-clear; a new event in the same cycle wins the clear.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= 8'h00;
            irq <= 1'b0;
        end else begin
            if (wr_en && bus_req.addr == OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~bus_req.wdata) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ********************************************************
    // Read path.
    // ********************************************************
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (bus_req.addr)
            OFS_PIN_CTRL: begin
                rdata_nxt = pin_ctrl_r;
                rdata_nxt[BIT_IRQ_IN] = irq_in;
                rdata_nxt[BIT_GP1_IN] = gp_pin_one_in;
                rdata_nxt[BIT_GP0_IN] = gp_pin_zero_in;
            end
            OFS_RSVD7: rdata_nxt = RST_RSVD7;
            OFS_SYNC_FILT: rdata_nxt = {RST_SYNC_FILT[7:2], sync_filt_r};
            OFS_RSVD9: rdata_nxt = RST_RSVD9;
            OFS_RSVD10: rdata_nxt = RST_RSVD10;
            OFS_RSVD11: rdata_nxt = RST_RSVD11;
            OFS_ERR_THR: rdata_nxt = err_thr_r;
            OFS_DEC_ERR: rdata_nxt = decode_error_count_r;
            OFS_PAT_ERR: rdata_nxt = pattern_error_count_r;
            OFS_AUD_CLK: rdata_nxt = aud_clk_r;
            OFS_RSVD19: rdata_nxt = {3'h0, RST_RSVD19};
            OFS_IRQ_STAT: rdata_nxt = irq_stat_r;
            OFS_IRQ_MASK: rdata_nxt = irq_mask_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= bus_req.rd ? rdata_nxt : 8'h00;
        end
    end

    // ********************************************************
    // Assertions.
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_auto_clear_count: assert property (
        auto_error_clear |=> decode_error_count_r == 8'h00
            && pattern_error_count_r == 8'h00 && error_n)
        else $error("Auto clear left errors standing.");
    a_forward_gate: assert property (
        irq_forward |-> $past(irq_in) && !$past(irq_forward_disable))
        else $error("Interrupt forwarded while disabled.");
    a_irq_level_read: assert property (
        bus_req.rd && bus_req.addr == OFS_PIN_CTRL
            |=> rdata[BIT_IRQ_IN] == $past(irq_in))
        else $error("Interrupt level readback wrong.");
    a_pin_one_drive: assert property (
        ##1 gp_pin_one_out == $past(pin_ctrl_r[BIT_GP1_OUT]))
        else $error("Pin one drive mismatch.");
    a_pin_zero_drive: assert property (
        ##1 gp_pin_zero_out == $past(pin_ctrl_r[BIT_GP0_OUT]))
        else $error("Pin zero drive mismatch.");
    a_vs_bypass: assert property (
        sync_filt_r[BIT_VS_FILT_DIS] |=> vsync_out == $past(vsync_in))
        else $error("Vsync bypass not taken.");
    a_hs_bypass: assert property (
        sync_filt_r[BIT_HS_FILT_DIS] |=> hsync_out == $past(hsync_in))
        else $error("Hsync bypass not taken.");
    a_error_out: assert property (
        !error_n |-> $past(error_active))
        else $error("Error output without threshold crossing.");
    a_dec_count_step: assert property (
        !pattern_mode && !auto_error_clear && decode_error
            && decode_error_count_r < 8'hFF
            |=> decode_error_count_r == $past(decode_error_count_r) + 8'h01)
        else $error("Decode counter did not step.");
    a_dec_hold_zero: assert property (
        pattern_mode |=> decode_error_count_r == 8'h00)
        else $error("Decode counter moved in pattern mode.");
    a_pat_count_step: assert property (
        pattern_mode && pattern_error && !auto_error_clear
            && pattern_error_count_r < 8'hFF
            |=> pattern_error_count_r == $past(pattern_error_count_r) + 8'h01)
        else $error("Pattern counter did not step.");
    a_mclk_off: assert property (
        div_val == 7'h00 |=> !audio_mclk)
        else $error("Audio clock runs with zero divider.");

    c_error_low: cover property (!error_n);
    c_forward: cover property (irq_forward);
    c_mclk_edge: cover property (audio_mclk && !$past(audio_mclk));
    c_irq_out: cover property (irq);

endmodule

`default_nettype wire

// file: tb.sv
// Self-checking testbench for the deserializer status and pin registers.
`timescale 1ns/10ps
`default_nettype none

module tb;
    import deser_regs_pkg::*;

    // ****************************************************
    // Signals, tables and counters.
    // ****************************************************
    logic clock, rst_n, irq_in, irq_forward, irq; // Clock, reset, irq.
    bus_req_s bus_req; // Register request.
    logic [7:0] rdata, d, w, thr; // Read data and scratch values.
    logic g1i, g1o, g1e, g0i, g0o, g0e; // General-purpose pins.
    logic vsi, hsi, vso, hso, dec_e, pat_m, pat_e, error_n; // Syncs, errors.
    logic pix, osc, mclk; // Audio clock sources and output.
    int n_errors = 0, compares = 0, cyc = 0, t, n; // Counters.
    logic [31:0] seed = 32'h1D10; // Fixed seed keeps runs repeatable.
    logic [7:0] ra [13] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
        8'h0C, 8'h0D, 8'h0E, 8'h12, 8'h13, 8'h21, 8'h30};
    logic [7:0] rv [13] = '{8'h0A, 8'h54, 8'h30, 8'hC8, 8'h12, 8'h20,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
    int ro [8] = '{1, 3, 4, 5, 7, 8, 10, 12}; // Places that ignore writes.
    logic [7:0] ac [4] = '{8'h81, 8'h83, 8'h01, 8'h02}; // Audio settings.

    deser_status_gpio_regs u_deser_status_gpio_regs (
        .clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
        .irq_in(irq_in), .irq_forward(irq_forward), .gp_pin_one_in(g1i),
        .gp_pin_one_out(g1o), .gp_pin_one_oe(g1e), .gp_pin_zero_in(g0i),
        .gp_pin_zero_out(g0o), .gp_pin_zero_oe(g0e), .vsync_in(vsi),
        .hsync_in(hsi), .vsync_out(vso), .hsync_out(hso),
        .decode_error(dec_e), .pattern_mode(pat_m),
        .pattern_error(pat_e), .error_n(error_n),
        .recovered_pixel_clock(pix), .osc_clock(osc),
        .audio_mclk(mclk), .irq(irq));

    // ****************************************************
    // Helpers: random source, expectations, bus and checks.
    // ****************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Source edges seen in a 48-cycle window, divided down.
    function automatic int exp_tog(input logic [7:0] c);
        return (c[6:0] == 0) ? 0 : 48 / ((c[7] ? 2 : 4) * c[6:0]);
    endfunction

    task automatic chk_reg(input logic [7:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic chk_pin(input logic g, e, input string m);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %b", $time, m, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, v);
        @(posedge clock);
        bus_req <= {a, v, 1'b1, 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, e, input string m);
        @(posedge clock);
        bus_req <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1 chk_reg(rdata, e, m);
    endtask

    // Back-to-back event pulses, one per cycle.
    task automatic pulses(input int k, input logic p);
        repeat (k) begin
            @(posedge clock);
            dec_e <= 1'b1;
            pat_e <= p;
        end
        @(posedge clock);
        dec_e <= 1'b0;
        pat_e <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic count_mclk(output int k);
        logic last;
        k = 0;
        repeat (10) @(posedge clock);
        #1 last = mclk;
        repeat (48) begin
            @(posedge clock);
            #1 k = k + int'(mclk !== last);
            last = mclk;
        end
    endtask

    task automatic complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Source clocks run off the cycle count; a hang ends the run.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        osc <= cyc[0];
        pix <= cyc[1];
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    // ****************************************************
    // Main sequence.
    // ****************************************************
    initial begin
        {rst_n, irq_in, g1i, g0i, vsi, hsi, dec_e, pat_m, pat_e} = '0;
        bus_req = '0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 13; i++) rd_chk(ra[i], rv[i], "reset");
        for (int i = 0; i < 8; i++) wr(ra[ro[i]], 8'hFF);
        for (int i = 0; i < 8; i++) rd_chk(ra[ro[i]], rv[ro[i]], "ro");
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            w = (i == 0) ? 8'h95 : seed[7:0];
            @(posedge clock);
            {irq_in, g1i, g0i} <= seed[10:8];
            wr(OFS_PIN_CTRL, w);
            w = w & 8'h6A;
            repeat (3) @(posedge clock);
            #1 chk_pin(irq_forward, seed[10] & ~w[5], "fwd");
            chk_pin(g1o & g1e, w[3], "pin one");
            chk_pin(g0o & g0e, w[1], "pin zero");
            d = w | {3'h0, seed[10], 1'b0, seed[9], 1'b0, seed[8]};
            rd_chk(OFS_PIN_CTRL, d, "pins");
        end
        @(posedge clock);
        {vsi, hsi} <= 2'b11;
        @(posedge clock);
        {vsi, hsi} <= 2'b00;
        repeat (6) begin
            @(posedge clock) #1 chk_pin(vso | hso, 1'b0, "glt");
        end
        @(posedge clock) {vsi, hsi} <= 2'b11;
        repeat (8) @(posedge clock);
        #1 chk_pin(vso & hso, 1'b1, "held level");
        wr(OFS_SYNC_FILT, 8'hFF);
        rd_chk(OFS_SYNC_FILT, 8'h33, "filter ctl");
        @(posedge clock) {vsi, hsi} <= 2'b00;
        @(posedge clock);
        #1 chk_pin(vso | hso, 1'b0, "bypass");
        for (int i = 0; i < 5; i++) begin
            seed = xs(seed);
            thr = (i == 0) ? 8'hFF : {4'h0, seed[11:8]};
            n = (i == 0) ? 260 : ((i == 1) ? int'(thr) : int'(seed[4:0]));
            // One pass must cross the threshold so the error pin falls.
            if (i == 2) n = int'(thr) + 1;
            wr(OFS_ERR_THR, thr);
            wr(OFS_PIN_CTRL, 8'h4A);
            rd_chk(OFS_DEC_ERR, 8'h00, "auto clear");
            chk_pin(error_n, 1'b1, "clear out");
            wr(OFS_PIN_CTRL, 8'h0A);
            pulses(n, 1'b0);
            // The counter saturates, so compare against the held value.
            if (n > 255) n = 255;
            rd_chk(OFS_ERR_THR, thr, "thr");
            rd_chk(OFS_DEC_ERR, (n > 255) ? 8'hFF : n[7:0], "dec");
            chk_pin(error_n, !(n > int'(thr)), "err out");
        end
        @(posedge clock) pat_m <= 1'b1;
        pulses(5, 1'b1);
        rd_chk(OFS_DEC_ERR, 8'h00, "pattern hold");
        rd_chk(OFS_PAT_ERR, 8'h05, "pattern count");
        @(posedge clock) pat_m <= 1'b0;
        pulses(3, 1'b1);
        rd_chk(OFS_PAT_ERR, 8'h05, "pattern off");
        rd_chk(OFS_DEC_ERR, 8'h03, "decode resumes");
        rd_chk(OFS_IRQ_STAT, 8'h07, "status");
        chk_pin(irq, 1'b0, "masked");
        wr(OFS_IRQ_MASK, 8'h02);
        repeat (2) @(posedge clock);
        #1 chk_pin(irq, 1'b1, "unmasked");
        wr(OFS_IRQ_STAT, 8'h02);
        repeat (2) @(posedge clock);
        #1 chk_pin(irq, 1'b0, "cleared");
        rd_chk(OFS_IRQ_STAT, 8'h05, "w1c");
        count_mclk(t);
        chk_pin(t == 0 && mclk === 1'b0, 1'b1, "mclk off");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_AUD_CLK, ac[i]);
            rd_chk(OFS_AUD_CLK, ac[i], "aud ctl");
            count_mclk(t);
            chk_pin(t >= exp_tog(ac[i]) - 1 && t <= exp_tog(ac[i]) + 1,
                1'b1, "mclk rate");
        end
        complete_run();
    end
endmodule
`default_nettype wire
